//--- verilog/spc_pkg.sv
// Constants and types for the output port and control pin block
// Overview of operation
// - During power-down all three output serial data lines are driven low.
// - In clock master mode, power-down holds bit clock and channel clock low.
// - During power-down the crystal drive pin floats (high impedance).
// - Power-down with channel mode bit 2 high drives master clock output low.
// - Power-down with channel mode bit 2 low floats the master clock output.
// - Mute mode strap high selects semi-automatic soft mute, low selects manual.
// - Control mode strap high uses serial registers, low uses strap pins.
// - I2C pins serve as control bus only in serial mode; grounded otherwise.
// - Three clock/mode straps choose output clock ratio or output port mode.
// - Two format straps choose the output serial framing format.
// - Power-down low resets the device and its control registers.
package spc_pkg;

  // Control sequence states, one-hot
  typedef enum logic [2:0] {
    SPC_ST_PD = 3'h1,
    SPC_ST_CAPT = 3'h2,
    SPC_ST_RUN = 3'h4
  } spc_state_t;

  // Output clock or mode codes
  localparam logic [2:0] SPC_CM_MST_128 = 3'h0;
  localparam logic [2:0] SPC_CM_MST_256 = 3'h1;
  localparam logic [2:0] SPC_CM_MST_384 = 3'h2;
  localparam logic [2:0] SPC_CM_MST_512 = 3'h3;
  localparam logic [2:0] SPC_CM_MST_768 = 3'h4;
  localparam logic [2:0] SPC_CM_SLAVE = 3'h5;
  localparam logic [2:0] SPC_CM_BYP_MST = 3'h6;
  localparam logic [2:0] SPC_CM_BYP_SLV = 3'h7;

  // Output framing format codes
  localparam logic [1:0] SPC_FMT_LSB = 2'h0;
  localparam logic [1:0] SPC_FMT_MSB = 2'h1;
  localparam logic [1:0] SPC_FMT_I2S = 2'h2;
  localparam logic [1:0] SPC_FMT_TDM = 2'h3;

  // Synchronised input vector layout
  localparam int SPC_SYNC_W = 14;
  localparam int SPC_POS_PDN = 0;
  localparam int SPC_POS_CM = 1;
  localparam int SPC_POS_FMT = 4;
  localparam int SPC_POS_PM2 = 6;
  localparam int SPC_POS_SEMI = 7;
  localparam int SPC_POS_SPB = 8;
  localparam int SPC_POS_CAD = 9;
  localparam int SPC_POS_SCL = 10;
  localparam int SPC_POS_SDA = 11;
  localparam int SPC_POS_BCK = 12;
  localparam int SPC_POS_LRK = 13;

  // Latched strap vector: cm(3) fmt(2) pm2 semi spb cad
  localparam int SPC_STRAP_W = 9;
  localparam logic [8:0] SPC_STRAP_RST = 9'h000;
  // Synchroniser reset: power-down asserted, lines idle low
  localparam logic [13:0] SPC_SYNC_RST = 14'h0000;

endpackage : spc_pkg

//--- verilog/spc_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module spc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Pin side and filtered level
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // Accept a change only when stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      lvl_q <= RST;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule // spc_sync3
`default_nettype wire

//--- verilog/spc_strap_hold.sv
// Strap capture register, loaded on a single-cycle strobe
`timescale 1ns/1ns
`default_nettype none
module spc_strap_hold (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Capture strobe and strap values
  input wire logic capture_in,
  input wire logic [spc_pkg::SPC_STRAP_W-1:0] strap_in,
  output logic [spc_pkg::SPC_STRAP_W-1:0] strap_out
);

  logic [spc_pkg::SPC_STRAP_W-1:0] strap_q, strap_d;

  // Hold everything between captures
  always_comb
  begin
    strap_d = capture_in ? strap_in : strap_q;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      strap_q <= spc_pkg::SPC_STRAP_RST;
    else
      strap_q <= strap_d;
  end

  assign strap_out = strap_q;

endmodule // spc_strap_hold
`default_nettype wire

//--- verilog/spc_top.sv
// Output port pin control, strap decode and control mode gating
`timescale 1ns/1ns
`default_nettype none
module spc_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Power-down and strap pins
  input wire logic power_down_n_in,
  input wire logic out_clock_mode_sel_b2_in,
  input wire logic out_clock_mode_sel_b1_in,
  input wire logic out_clock_mode_sel_b0_in,
  input wire logic out_format_sel_b1_in,
  input wire logic out_format_sel_b0_in,
  input wire logic channel_mode_sel_b2_in,
  input wire logic mute_semi_auto_sel_in,
  input wire logic control_mode_sel_in,
  input wire logic chip_addr_strap_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Output port clocks, two-way
  input wire logic out_bit_clock_in,
  output logic out_bit_clock_out,
  output logic out_bit_clock_oe_out,
  input wire logic out_channel_clock_in,
  output logic out_channel_clock_out,
  output logic out_channel_clock_oe_out,
  // Output serial data pins
  output logic serial_data_out_1_out,
  output logic serial_data_out_2_out,
  output logic serial_data_out_3_out,
  // Crystal and master clock output pins
  output logic crystal_drive_out_out,
  output logic crystal_drive_oe_out,
  output logic master_clock_out_out,
  output logic master_clock_oe_out,
  // From the converter core
  input wire logic [2:0] core_sdata_in,
  input wire logic core_bclk_in,
  input wire logic core_lrck_in,
  input wire logic core_mclk_in,
  input wire logic core_xtal_in,
  input wire logic core_sda_pull_in,
  // To the converter core
  output logic core_reset_n_out,
  output logic straps_valid_out,
  output logic cfg_from_serial_out,
  output logic mute_semi_auto_out,
  output logic [2:0] clock_mode_code_out,
  output logic master_mode_out,
  output logic bypass_mode_out,
  output logic [1:0] format_code_out,
  output logic chip_addr_bit_out,
  output logic i2c_scl_out,
  output logic i2c_sda_out,
  output logic link_bclk_rise_out,
  output logic link_bclk_fall_out,
  output logic link_lrck_edge_out
);

  // Master when the device itself makes the port clocks
  function automatic logic is_master(input logic [2:0] cm);
    is_master = (cm != spc_pkg::SPC_CM_SLAVE) && (cm != spc_pkg::SPC_CM_BYP_SLV);
  endfunction

  logic [spc_pkg::SPC_SYNC_W-1:0] pin_vec, sync_vec;
  logic [spc_pkg::SPC_STRAP_W-1:0] strap_live, strap_held;
  logic pdn_s, pm2_s, capture;
  logic [2:0] cm_live;
  spc_pkg::spc_state_t st_q, st_d;

  // Every pin input is asynchronous to the internal clock
  assign pin_vec = {out_channel_clock_in, out_bit_clock_in, sda_in, scl_in,
                    chip_addr_strap_in, control_mode_sel_in, mute_semi_auto_sel_in,
                    channel_mode_sel_b2_in, out_format_sel_b1_in, out_format_sel_b0_in,
                    out_clock_mode_sel_b2_in, out_clock_mode_sel_b1_in, out_clock_mode_sel_b0_in,
                    power_down_n_in};

  spc_sync3 #(
    .W(spc_pkg::SPC_SYNC_W),
    .RST(spc_pkg::SPC_SYNC_RST)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .pin_in(pin_vec),
    .level_out(sync_vec)
  );

  assign pdn_s = sync_vec[spc_pkg::SPC_POS_PDN];
  assign pm2_s = sync_vec[spc_pkg::SPC_POS_PM2];
  assign cm_live = sync_vec[spc_pkg::SPC_POS_CM +: 3];
  assign strap_live = sync_vec[spc_pkg::SPC_POS_CM +: spc_pkg::SPC_STRAP_W];

  // Power-down sequence
  always_comb
  begin
    case (st_q)
      spc_pkg::SPC_ST_PD: st_d = pdn_s ? spc_pkg::SPC_ST_CAPT : spc_pkg::SPC_ST_PD;
      spc_pkg::SPC_ST_CAPT: st_d = pdn_s ? spc_pkg::SPC_ST_RUN : spc_pkg::SPC_ST_PD;
      spc_pkg::SPC_ST_RUN: st_d = pdn_s ? spc_pkg::SPC_ST_RUN : spc_pkg::SPC_ST_PD;
      default: st_d = spc_pkg::SPC_ST_PD;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      st_q <= spc_pkg::SPC_ST_PD;
    else
      st_q <= st_d;
  end

  // capture at release
  // Straps are trusted only once power-down ends; changing them later is ignored
  assign capture = (st_q == spc_pkg::SPC_ST_CAPT);

  spc_strap_hold u_hold (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .capture_in(capture),
    .strap_in(strap_live),
    .strap_out(strap_held)
  );

  // core reset
  // Control registers are held reset for the whole power-down
  assign core_reset_n_out = (st_q == spc_pkg::SPC_ST_RUN);
  assign straps_valid_out = (st_q == spc_pkg::SPC_ST_RUN);

  assign clock_mode_code_out = strap_held[2:0];
  assign master_mode_out = is_master(strap_held[2:0]);
  assign bypass_mode_out = (strap_held[2:0] == spc_pkg::SPC_CM_BYP_MST) ||
                           (strap_held[2:0] == spc_pkg::SPC_CM_BYP_SLV);
  assign format_code_out = strap_held[4:3];
  assign mute_semi_auto_out = strap_held[6];
  assign cfg_from_serial_out = strap_held[7] & straps_valid_out;
  // address bit
  // Forced to zero in parallel mode in case the board leaves it high
  assign chip_addr_bit_out = cfg_from_serial_out & strap_held[8];

  // bus gating
  // Idle-high lines to the I2C engine so no false start appears in parallel mode
  assign i2c_scl_out = cfg_from_serial_out ? sync_vec[spc_pkg::SPC_POS_SCL] : 1'b1;
  assign i2c_sda_out = cfg_from_serial_out ? sync_vec[spc_pkg::SPC_POS_SDA] : 1'b1;

  // Link clock edge detection, slave mode only
  logic bck_q, lrk_q, rise_q, fall_q, ledge_q;
  logic bck_d, lrk_d, rise_d, fall_d, ledge_d;
  logic slave_run;

  assign slave_run = straps_valid_out & ~master_mode_out;

  always_comb
  begin
    bck_d = sync_vec[spc_pkg::SPC_POS_BCK];
    lrk_d = sync_vec[spc_pkg::SPC_POS_LRK];
    rise_d = slave_run & bck_d & ~bck_q;
    fall_d = slave_run & ~bck_d & bck_q;
    ledge_d = slave_run & (lrk_d ^ lrk_q);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      bck_q <= 1'b0;
      lrk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      ledge_q <= 1'b0;
    end
    else
    begin
      bck_q <= bck_d;
      lrk_q <= lrk_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      ledge_q <= ledge_d;
    end
  end

  assign link_bclk_rise_out = rise_q;
  assign link_bclk_fall_out = fall_q;
  assign link_lrck_edge_out = ledge_q;

  // Registered pin drivers
  logic [2:0] sd_q, sd_d;
  logic bo_q, bo_d, boe_q, boe_d, lo_q, lo_d, loe_q, loe_d;
  logic xo_q, xo_d, xoe_q, xoe_d, mo_q, mo_d, moe_q, moe_d;
  logic run;

  assign run = (st_q == spc_pkg::SPC_ST_RUN);

  always_comb
  begin
    sd_d = run ? core_sdata_in : 3'h0;
    // clocks low in master
    // In power-down the live straps decide direction, since held ones may be stale
    boe_d = run ? master_mode_out : is_master(cm_live);
    loe_d = boe_d;
    bo_d = run & master_mode_out & core_bclk_in;
    lo_d = run & master_mode_out & core_lrck_in;
    xoe_d = run;
    xo_d = run & core_xtal_in;
    moe_d = run | pm2_s;
    mo_d = run & core_mclk_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      sd_q <= 3'h0;
      bo_q <= 1'b0;
      boe_q <= 1'b0;
      lo_q <= 1'b0;
      loe_q <= 1'b0;
      xo_q <= 1'b0;
      xoe_q <= 1'b0;
      mo_q <= 1'b0;
      moe_q <= 1'b0;
    end
    else
    begin
      sd_q <= sd_d;
      bo_q <= bo_d;
      boe_q <= boe_d;
      lo_q <= lo_d;
      loe_q <= loe_d;
      xo_q <= xo_d;
      xoe_q <= xoe_d;
      mo_q <= mo_d;
      moe_q <= moe_d;
    end
  end

  assign serial_data_out_1_out = sd_q[0];
  assign serial_data_out_2_out = sd_q[1];
  assign serial_data_out_3_out = sd_q[2];
  assign out_bit_clock_out = bo_q;
  assign out_bit_clock_oe_out = boe_q;
  assign out_channel_clock_out = lo_q;
  assign out_channel_clock_oe_out = loe_q;
  assign crystal_drive_out_out = xo_q;
  assign crystal_drive_oe_out = xoe_q;
  assign master_clock_out_out = mo_q;
  assign master_clock_oe_out = moe_q;

  // open-drain data
  // Only pulls low, and never in parallel mode where the pin is grounded
  assign sda_out = 1'b0;
  assign sda_oe_out = cfg_from_serial_out & core_sda_pull_in;

  a_data_low_pd: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !run |=> (sd_q == 3'h0))
    else $error("serial data not low in power-down");

  a_mst_clk_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!run && is_master(cm_live)) |=> (boe_q && loe_q && !bo_q && !lo_q))
    else $error("master clocks not held low in power-down");

  a_xtal_hiz: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !run |=> !xoe_q)
    else $error("crystal drive not floating in power-down");

  a_mck_low_pd: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!run && pm2_s) |=> (moe_q && !mo_q))
    else $error("master clock not low in power-down");

  a_mck_hiz_pd: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!run && !pm2_s) |=> !moe_q)
    else $error("master clock not floating in power-down");

  a_mute_mode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    capture |=> (mute_semi_auto_out == $past(sync_vec[spc_pkg::SPC_POS_SEMI])))
    else $error("soft mute mode not taken from strap");

  a_i2c_gated: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !cfg_from_serial_out |-> (i2c_scl_out && i2c_sda_out && !sda_oe_out))
    else $error("control bus active outside serial mode");

  a_core_reset: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !pdn_s |=> !core_reset_n_out)
    else $error("core not reset during power-down");

  a_strap_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (run && $past(run)) |-> $stable(strap_held))
    else $error("straps changed while running");

  a_master_dec: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (run && (clock_mode_code_out == spc_pkg::SPC_CM_SLAVE)) |=> !boe_q)
    else $error("slave mode drives port clocks");

endmodule // spc_top
`default_nettype wire

//--- testbench/spc_rx_model.sv
// Downstream receiver model that makes the output port clocks in slave mode
`timescale 1ns/1ns
`default_nettype none
module spc_rx_model (
  // Frame enable from the bench
  input wire logic run_in,
  // Port clocks and count of bit clock rises
  output logic bclk_out,
  output logic lrck_out,
  output int rise_cnt_out
);
  int half_cnt;

  // Bit clock of 80 ns, odd start so it never lines up with the system clock;
  // it finishes its high half and then stands low between frames
  initial
  begin
    bclk_out = 1'b0;
    lrck_out = 1'b0;
    rise_cnt_out = 0;
    half_cnt = 0;
    #3;
    forever
    begin
      #40;
      if (run_in || bclk_out)
      begin
        bclk_out = ~bclk_out;
        half_cnt++;
        if (bclk_out)
          rise_cnt_out++;
        if (half_cnt % 16 == 0)
          lrck_out = ~lrck_out;
      end
    end
  end
endmodule // spc_rx_model
`default_nettype wire

//--- testbench/spc_top_test.sv
// Self-checking bench for the output port pin control block
`timescale 1ns/1ns
`default_nettype none
module spc_top_test;
  logic clk_sys_in, rstn_in, power_down_n_in, out_clock_mode_sel_b2_in, out_clock_mode_sel_b1_in;
  logic out_clock_mode_sel_b0_in, out_format_sel_b1_in, out_format_sel_b0_in, channel_mode_sel_b2_in;
  logic mute_semi_auto_sel_in, control_mode_sel_in, chip_addr_strap_in, scl_in, sda_lvl, m_run;
  logic core_bclk_in, core_lrck_in, core_mclk_in, core_xtal_in, core_sda_pull_in, m_bclk, m_lrck;
  logic [2:0] core_sdata_in, clock_mode_code_out;
  logic [1:0] format_code_out;
  logic sda_out, sda_oe_out, out_bit_clock_out, out_bit_clock_oe_out, out_channel_clock_out;
  logic out_channel_clock_oe_out, serial_data_out_1_out, serial_data_out_2_out, serial_data_out_3_out;
  logic crystal_drive_out_out, crystal_drive_oe_out, master_clock_out_out, master_clock_oe_out;
  logic core_reset_n_out, straps_valid_out, cfg_from_serial_out, mute_semi_auto_out, master_mode_out;
  logic bypass_mode_out, chip_addr_bit_out, i2c_scl_out, i2c_sda_out, link_bclk_rise_out;
  logic link_bclk_fall_out, link_lrck_edge_out;
  wire logic sda_in, out_bit_clock_in, out_channel_clock_in;
  int n_errors = 0, samples_checked = 0, cycles = 0, n_rise = 0, n_fall = 0, n_ledge = 0, m_rises;

  // Wire levels: SDA at the bench level sda_lvl unless pulled low, port clocks from whichever side drives
  assign sda_in = sda_oe_out ? sda_out : sda_lvl;
  assign out_bit_clock_in = out_bit_clock_oe_out ? out_bit_clock_out : m_bclk;
  assign out_channel_clock_in = out_channel_clock_oe_out ? out_channel_clock_out : m_lrck;

  spc_top dut (.clk_sys_in, .rstn_in, .power_down_n_in, .out_clock_mode_sel_b2_in, .out_clock_mode_sel_b1_in,
    .out_clock_mode_sel_b0_in, .out_format_sel_b1_in, .out_format_sel_b0_in, .channel_mode_sel_b2_in,
    .mute_semi_auto_sel_in, .control_mode_sel_in, .chip_addr_strap_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .out_bit_clock_in, .out_bit_clock_out, .out_bit_clock_oe_out, .out_channel_clock_in, .out_channel_clock_out,
    .out_channel_clock_oe_out, .serial_data_out_1_out, .serial_data_out_2_out, .serial_data_out_3_out,
    .crystal_drive_out_out, .crystal_drive_oe_out, .master_clock_out_out, .master_clock_oe_out, .core_sdata_in,
    .core_bclk_in, .core_lrck_in, .core_mclk_in, .core_xtal_in, .core_sda_pull_in, .core_reset_n_out,
    .straps_valid_out, .cfg_from_serial_out, .mute_semi_auto_out, .clock_mode_code_out, .master_mode_out,
    .bypass_mode_out, .format_code_out, .chip_addr_bit_out, .i2c_scl_out, .i2c_sda_out, .link_bclk_rise_out,
    .link_bclk_fall_out, .link_lrck_edge_out);

  spc_rx_model rx (.run_in(m_run), .bclk_out(m_bclk), .lrck_out(m_lrck), .rise_cnt_out(m_rises));

  // 100 MHz system clock
  initial
    clk_sys_in = 1'b0;
  always #5 clk_sys_in = ~clk_sys_in;

  // Hang guard and count of link pulses, sampled mid-cycle where they stand
  always @(negedge clk_sys_in)
  begin
    cycles++;
    if (link_bclk_rise_out === 1'b1)
      n_rise++;
    if (link_bclk_fall_out === 1'b1)
      n_fall++;
    if (link_lrck_edge_out === 1'b1)
      n_ledge++;
    if (cycles == 5000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic straps(input logic [2:0] cm, input logic [1:0] f, input logic pm2, semi, control_mode_sel, cad);
    @(posedge clk_sys_in);
    {out_clock_mode_sel_b2_in, out_clock_mode_sel_b1_in, out_clock_mode_sel_b0_in} <= cm;
    {out_format_sel_b1_in, out_format_sel_b0_in} <= f;
    channel_mode_sel_b2_in <= pm2;
    mute_semi_auto_sel_in <= semi;
    control_mode_sel_in <= control_mode_sel;
    chip_addr_strap_in <= cad;
  endtask

  task automatic pdn_low();
    @(posedge clk_sys_in);
    power_down_n_in <= 1'b0;
    cyc(10);
  endtask

  // Release power-down and wait a bounded time for the straps to be held
  task automatic release_pd();
    int i;
    cyc(6);
    power_down_n_in <= 1'b1;
    // Polled mid-cycle so the state register has settled
    for (i = 0; i < 20 && straps_valid_out !== 1'b1; i++)
      @(negedge clk_sys_in);
    chk({core_reset_n_out, straps_valid_out}, 8'h3);
  endtask

  // Forced pin states in power-down with core lines all high
  task automatic t_pd();
    straps(3'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    pdn_low();
    @(negedge clk_sys_in);
    chk({serial_data_out_3_out, serial_data_out_2_out, serial_data_out_1_out}, 8'h0);
    chk({out_bit_clock_oe_out, out_bit_clock_out, out_channel_clock_oe_out, out_channel_clock_out}, 8'ha);
    chk(crystal_drive_oe_out, 8'h0);
    chk({master_clock_oe_out, master_clock_out_out}, 8'h2);
    chk({core_reset_n_out, straps_valid_out}, 8'h0);
    straps(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    @(negedge clk_sys_in);
    chk(master_clock_oe_out, 8'h0);
  endtask

  // One clock/mode code with a format, then a strap change in run that must be ignored
  task automatic t_cfg(input logic [2:0] c);
    logic m;
    m = (c <= 3'h4) || (c == 3'h6);
    pdn_low();
    straps(c, c[1:0], 1'b1, c[0], c[1], 1'b0);
    release_pd();
    chk(clock_mode_code_out, c);
    chk({master_mode_out, bypass_mode_out}, {m, c[2] & c[1]});
    chk(format_code_out, c[1:0]);
    chk(mute_semi_auto_out, c[0]);
    chk(cfg_from_serial_out, c[1]);
    straps(~c, ~c[1:0], 1'b1, ~c[0], c[1], 1'b1);
    core_sdata_in <= ~c;
    cyc(8);
    @(negedge clk_sys_in);
    chk({serial_data_out_3_out, serial_data_out_2_out, serial_data_out_1_out}, {~c});
    chk({clock_mode_code_out, format_code_out, mute_semi_auto_out}, {c, c[1:0], c[0]});
    chk(chip_addr_bit_out, 8'h0);
    chk({out_bit_clock_oe_out, out_bit_clock_out, out_channel_clock_oe_out, out_channel_clock_out}, {4{m}});
    chk({crystal_drive_oe_out, crystal_drive_out_out, master_clock_oe_out, master_clock_out_out}, 8'hf);
  endtask

  // I2C pins and chip address in parallel and serial control
  task automatic t_i2c(input logic s);
    pdn_low();
    straps(3'h0, 2'h0, 1'b0, 1'b0, s, s);
    scl_in <= s;
    sda_lvl <= s;
    release_pd();
    chk({cfg_from_serial_out, chip_addr_bit_out}, {s, s});
    @(posedge clk_sys_in);
    scl_in <= 1'b0;
    core_sda_pull_in <= 1'b1;
    cyc(6);
    @(negedge clk_sys_in);
    chk({i2c_scl_out, sda_oe_out, i2c_sda_out}, s ? 8'h2 : 8'h5);
    // bus pins back to ground for later parallel runs
    @(posedge clk_sys_in);
    core_sda_pull_in <= 1'b0;
    sda_lvl <= 1'b0;
  endtask

  // Slave mode: partner makes the bit clock, every rise must be seen once
  task automatic t_link();
    int b0, m0, f0, l0;
    pdn_low();
    straps(3'h5, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    release_pd();
    chk(out_bit_clock_oe_out, 8'h0);
    b0 = n_rise;
    f0 = n_fall;
    l0 = n_ledge;
    m0 = m_rises;
    m_run <= 1'b1;
    cyc(200);
    m_run <= 1'b0;
    cyc(20);
    chk(n_rise - b0, m_rises - m0);
    chk(n_fall - f0, m_rises - m0);
    chk(n_ledge - l0, (m_rises - m0) / 8);
  endtask

  // Main sequence
  initial
  begin
    {rstn_in, power_down_n_in, m_run, scl_in, sda_lvl, core_sda_pull_in} = 6'h0;
    {core_sdata_in, core_bclk_in, core_lrck_in, core_mclk_in, core_xtal_in} = 7'h7f;
    straps(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(2);
    rstn_in <= 1'b1;
    t_pd();
    for (int k = 0; k < 8; k++)
      t_cfg(k[2:0]);
    t_i2c(1'b0);
    t_i2c(1'b1);
    t_link();
    results();
  end
endmodule // spc_top_test
`default_nettype wire
